// *** cru_stack_unit.sv ***
`timescale 1ns/1ps
`include "cru_regs.svh"
module cru_stack_unit (
   input  logic                clock,
   input  logic                sys_rst,
   input  logic                ce,
   input  logic                cmd_valid,
   output logic                cmd_ready,
   input  cru_pkg::cru_op_type cmd_op,
   input  logic [31:0]         cmd_value,
   input  logic [15:0]         cmd_target_sel,
   input  logic [31:0]         cmd_target_off,
   input  logic [1:0]          cmd_target_dpl,
   input  logic [15:0]         cmd_release,
   input  logic [31:0]         cmd_disp,
   input  logic                code_default_size,
   input  logic                gate_valid,
   input  logic [1:0]          gate_dpl,
   input  logic [15:0]         gate_code_sel,
   input  logic [31:0]         gate_entry_off,
   input  logic [1:0]          gate_code_dpl,
   input  logic [15:0]         tss_stack_selector,
   input  logic [31:0]         tss_stack_base,
   input  logic [31:0]         tss_stack_pointer,
   input  logic                stack_load,
   input  logic [15:0]         stack_load_sel,
   input  logic [31:0]         stack_load_base,
   input  logic [31:0]         stack_load_sp,
   input  logic                gpr_wr,
   input  logic [2:0]          gpr_wr_idx,
   input  logic [31:0]         gpr_wr_data,
   input  logic                flags_wr,
   input  logic [31:0]         flags_wr_data,
   input  logic                ip_load,
   input  logic [31:0]         ip_load_value,
   output logic                mem_req,
   output logic                mem_we,
   output logic                mem_wide,
   output logic [31:0]         mem_addr,
   output logic [31:0]         mem_wdata,
   input  logic                mem_ack,
   input  logic [31:0]         mem_rdata,
   output logic [31:0]         instruction_pointer,
   output logic [15:0]         code_selector,
   output logic [31:0]         stack_pointer,
   output logic [31:0]         frame_base_pointer,
   output logic [31:0]         flags_register,
   output logic [15:0]         stack_selector,
   output logic [31:0]         stack_base,
   output logic [1:0]          privilege_level,
   output logic [15:0]         saved_stack_selector,
   output logic [31:0]         saved_stack_pointer,
   output logic [31:0]         load_data,
   output logic                fetch_start,
   output logic                op_done,
   output logic                protection_fault
);
   import cru_pkg::*;

   cru_state_type state;
   cru_op_type    op;
   logic [31:0]   gpr [0:7];
   logic [31:0]   item_val [0:7];
   logic [3:0]    item_dest [0:7];
   logic [7:0]    item_wide;
   logic [2:0]    idx;
   logic [2:0]    last;
   logic          d32;
   logic          is_frame;
   logic [15:0]   release_bytes;
   logic [15:0]   target_sel;
   logic [31:0]   target_off;
   logic [1:0]    target_pl;
   logic [31:0]   frame_disp;
   logic          accept;
   logic          load_en;
   logic          bad_far;
   logic          bad_gate;
   logic          inward;
   logic [31:0]   cur_step;
   logic [31:0]   sp_pushed;
   logic [31:0]   sp_popped;
   logic [31:0]   entry_sp;

   // A 16-bit stack only walks the low half; the upper half is left as it was.
   function automatic logic [31:0] cru_trim(input logic wide32, input logic [31:0] v);
      cru_trim = wide32 ? v : (v & `CRU_HALF_MASK);
   endfunction

   function automatic logic [31:0] cru_move(input logic wide32, input logic [31:0] sp,
                                            input logic [31:0] delta);
      cru_move = wide32 ? sp + delta : {sp[31:16], 16'(sp[15:0] + delta[15:0])};
   endfunction

   assign stack_pointer      = gpr[`CRU_IDX_SP];
   assign frame_base_pointer = gpr[`CRU_IDX_FBP];
   assign cmd_ready          = (state == CRU_ST_IDLE);
   assign accept             = ce && cmd_valid && (state == CRU_ST_IDLE);
   // Loads from the surrounding core only land while no command is offered.
   assign load_en            = ce && !cmd_valid && (state == CRU_ST_IDLE);
   assign cur_step           = item_wide[idx] ? `CRU_STEP_DWORD : `CRU_STEP_WORD; // RL1
   assign sp_pushed          = cru_move(d32, stack_pointer, 32'(-cur_step)); // RL18
   assign sp_popped          = cru_move(d32, stack_pointer, cur_step); // RL18
   assign bad_far            = cmd_target_dpl < privilege_level; // RL14
   assign bad_gate           = !gate_valid || (privilege_level > gate_dpl)
                               || (gate_code_dpl > privilege_level); // RL15
   assign inward             = gate_code_dpl < privilege_level; // RL14

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         state <= CRU_ST_IDLE;
      else if (ce)
      begin
         case (state)
            CRU_ST_IDLE:
               if (cmd_valid)
               begin
                  if ((cmd_op == CRU_OP_FAR_CALL && bad_far)
                      || (cmd_op == CRU_OP_GATE_CALL && bad_gate))
                     state <= CRU_ST_FAULT; // RL15
                  else if (cmd_op inside {CRU_OP_PUSH, CRU_OP_NEAR_CALL, CRU_OP_FAR_CALL,
                                          CRU_OP_GATE_CALL, CRU_OP_SAVE_ALL,
                                          CRU_OP_SAVE_FLW, CRU_OP_SAVE_FLD})
                     state <= CRU_ST_PUSH;
                  else
                     state <= CRU_ST_POP;
               end
            CRU_ST_PUSH:
               if (mem_req && mem_ack && idx == last)
                  state <= CRU_ST_DONE;
            CRU_ST_POP:
               if (mem_req && mem_ack && idx == last)
                  state <= (release_bytes != 16'h0) ? CRU_ST_ADJ : CRU_ST_DONE;
            CRU_ST_ADJ:
               state <= CRU_ST_DONE;
            CRU_ST_DONE:
               state <= CRU_ST_IDLE;
            CRU_ST_FAULT:
               state <= CRU_ST_IDLE;
            default:
               state <= CRU_ST_IDLE;
         endcase
      end
   end

   // Command capture: the whole transfer list is built at acceptance.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         op            <= CRU_OP_PUSH;
         last          <= 3'h0;
         d32           <= 1'b0;
         is_frame      <= 1'b0;
         release_bytes <= 16'h0;
         target_sel    <= `CRU_RST_SEL;
         target_off    <= `CRU_RST_WORD;
         target_pl     <= `CRU_PL_MOST;
         frame_disp    <= `CRU_RST_WORD;
         item_wide     <= 8'h00;
         entry_sp      <= `CRU_RST_WORD;
         for (int i = 0; i < 8; i++)
         begin
            item_val[i]  <= `CRU_RST_WORD;
            item_dest[i] <= `CRU_DEST_NONE;
         end
      end
      else if (accept)
      begin
         op            <= cmd_op;
         d32           <= code_default_size; // RL2
         is_frame      <= (cmd_op == CRU_OP_FRAME_READ);
         release_bytes <= (cmd_op inside {CRU_OP_NEAR_RET, CRU_OP_FAR_RET}) ? cmd_release
                                                                          : 16'h0;
         target_sel    <= (cmd_op == CRU_OP_GATE_CALL) ? gate_code_sel : cmd_target_sel; // RL16
         target_off    <= (cmd_op == CRU_OP_GATE_CALL) ? gate_entry_off : cmd_target_off;
         target_pl     <= gate_code_dpl;
         frame_disp    <= cmd_disp;
         entry_sp      <= stack_pointer;
         item_wide     <= {8{code_default_size}}; // RL1
         last          <= 3'h0;
         item_val[0]   <= cmd_value;
         item_dest[0]  <= `CRU_DEST_LOAD;
         case (cmd_op)
            CRU_OP_NEAR_CALL:
               item_val[0] <= instruction_pointer; // RL5 RL9
            CRU_OP_NEAR_RET:
               item_dest[0] <= `CRU_DEST_IP; // RL6
            CRU_OP_FAR_CALL, CRU_OP_GATE_CALL:
            begin
               item_val[0] <= {16'h0, code_selector}; // RL7 RL9
               item_val[1] <= instruction_pointer;
               last        <= 3'h1;
            end
            CRU_OP_FAR_RET:
            begin
               item_dest[0] <= `CRU_DEST_IP; // RL8
               item_dest[1] <= `CRU_DEST_CS;
               last         <= 3'h1;
            end
            CRU_OP_SAVE_ALL:
            begin
               for (int i = 0; i < 8; i++)
                  item_val[i] <= gpr[i]; // RL10
               last <= `CRU_LIST_LAST;
            end
            CRU_OP_RESTORE_ALL:
            begin
               // The pointer slot is skipped: the walk itself owns the pointer.
               for (int i = 0; i < 8; i++)
                  item_dest[i] <= (3'(7 - i) == `CRU_IDX_SI || 3'(7 - i) == `CRU_IDX_SP)
                                  ? `CRU_DEST_NONE : {1'b0, 3'(7 - i)}; // RL11
               last <= `CRU_LIST_LAST;
            end
            CRU_OP_SAVE_FLW:
            begin
               item_val[0]  <= flags_register & `CRU_HALF_MASK; // RL12
               item_wide[0] <= 1'b0;
            end
            CRU_OP_SAVE_FLD:
            begin
               item_val[0]  <= flags_register; // RL12
               item_wide[0] <= 1'b1;
            end
            CRU_OP_RESTORE_FLW:
            begin
               item_dest[0] <= `CRU_DEST_FLO; // RL13
               item_wide[0] <= 1'b0;
            end
            CRU_OP_RESTORE_FLD:
            begin
               item_dest[0] <= `CRU_DEST_FLAGS; // RL13
               item_wide[0] <= 1'b1;
            end
            default:
               item_dest[0] <= `CRU_DEST_LOAD;
         endcase
      end
   end

   // Memory side: one request stands until acknowledged, then the list advances.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_wide  <= 1'b0;
         mem_addr  <= `CRU_RST_WORD;
         mem_wdata <= `CRU_RST_WORD;
         idx       <= 3'h0;
      end
      else if (ce)
      begin
         if (state == CRU_ST_IDLE)
            idx <= 3'h0;
         if ((state == CRU_ST_PUSH || state == CRU_ST_POP) && !mem_req)
         begin
            mem_req   <= 1'b1;
            mem_we    <= (state == CRU_ST_PUSH);
            mem_wide  <= item_wide[idx];
            mem_wdata <= item_val[idx];
            if (state == CRU_ST_PUSH)
               mem_addr <= stack_base + cru_trim(d32, sp_pushed); // RL18 RL19
            else if (is_frame)
               mem_addr <= stack_base + cru_trim(d32, frame_base_pointer + frame_disp); // RL4
            else
               mem_addr <= stack_base + cru_trim(d32, stack_pointer); // RL19
         end
         else if (mem_req && mem_ack)
         begin
            mem_req <= 1'b0;
            idx     <= 3'(idx + 3'h1);
         end
      end
   end

   // Register file, stack pointer included.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 8; i++)
            gpr[i] <= `CRU_RST_WORD;
      end
      else if (ce)
      begin
         if (load_en && stack_load)
            gpr[`CRU_IDX_SP] <= stack_load_sp;
         else if (load_en && gpr_wr)
            gpr[gpr_wr_idx] <= gpr_wr_data;
         else if (accept && cmd_op == CRU_OP_GATE_CALL && !bad_gate && inward)
            gpr[`CRU_IDX_SP] <= tss_stack_pointer; // RL17
         else if (state == CRU_ST_PUSH && !mem_req)
            gpr[`CRU_IDX_SP] <= sp_pushed; // RL18
         else if (state == CRU_ST_POP && mem_req && mem_ack)
         begin
            if (!is_frame)
               gpr[`CRU_IDX_SP] <= sp_popped; // RL18
            if (!item_dest[idx][3])
               gpr[item_dest[idx][2:0]] <= cru_trim(item_wide[idx], mem_rdata); // RL11
         end
         else if (state == CRU_ST_ADJ)
            gpr[`CRU_IDX_SP] <= cru_move(d32, stack_pointer, {16'h0, release_bytes}); // RL6 RL8
      end
   end

   // Control registers and the stack switch on an inward gate call.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         instruction_pointer  <= `CRU_RST_WORD;
         code_selector        <= `CRU_RST_SEL;
         flags_register       <= `CRU_RST_FLAGS;
         stack_selector       <= `CRU_RST_SEL;
         stack_base           <= `CRU_RST_WORD;
         privilege_level      <= `CRU_PL_MOST;
         saved_stack_selector <= `CRU_RST_SEL;
         saved_stack_pointer  <= `CRU_RST_WORD;
         load_data            <= `CRU_RST_WORD;
      end
      else if (ce)
      begin
         if (load_en && stack_load)
         begin
            stack_selector <= stack_load_sel;
            stack_base     <= stack_load_base;
         end
         if (load_en && flags_wr)
            flags_register <= flags_wr_data;
         if (load_en && ip_load)
            instruction_pointer <= ip_load_value;
         if (accept && cmd_op == CRU_OP_GATE_CALL && !bad_gate && inward)
         begin
            saved_stack_selector <= stack_selector; // RL17
            saved_stack_pointer  <= stack_pointer;
            stack_selector       <= tss_stack_selector;
            stack_base           <= tss_stack_base;
         end
         if (state == CRU_ST_POP && mem_req && mem_ack)
         begin
            case (item_dest[idx])
               `CRU_DEST_IP:    instruction_pointer <= cru_trim(d32, mem_rdata); // RL6 RL8
               `CRU_DEST_CS:
               begin
                  code_selector <= mem_rdata[15:0]; // RL8
                  // A return may only move outward, never gain privilege.
                  if (mem_rdata[1:0] > privilege_level)
                     privilege_level <= mem_rdata[1:0];
               end
               `CRU_DEST_FLO:   flags_register[15:0] <= mem_rdata[15:0]; // RL13
               `CRU_DEST_FLAGS: flags_register <= mem_rdata; // RL13
               `CRU_DEST_LOAD:  load_data <= cru_trim(d32, mem_rdata);
               default:         load_data <= load_data;
            endcase
         end
         if (state == CRU_ST_DONE)
         begin
            if (op inside {CRU_OP_NEAR_CALL, CRU_OP_FAR_CALL, CRU_OP_GATE_CALL})
               instruction_pointer <= target_off; // RL5 RL7
            if (op inside {CRU_OP_FAR_CALL, CRU_OP_GATE_CALL})
               code_selector <= target_sel; // RL7 RL16
            if (op == CRU_OP_GATE_CALL)
               privilege_level <= target_pl; // RL16
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         fetch_start      <= 1'b0;
         op_done          <= 1'b0;
         protection_fault <= 1'b0;
      end
      else if (ce)
      begin
         op_done          <= (state == CRU_ST_DONE);
         protection_fault <= (state == CRU_ST_FAULT); // RL15
         fetch_start      <= (state == CRU_ST_DONE)
                             && (op inside {CRU_OP_NEAR_CALL, CRU_OP_NEAR_RET, CRU_OP_FAR_CALL,
                                            CRU_OP_FAR_RET, CRU_OP_GATE_CALL}); // RL5
      end
   end

   sequence s_push_issue;
      ce && state == CRU_ST_PUSH && !mem_req;
   endsequence

   sequence s_write_at_top;
      mem_req && mem_we && mem_addr == stack_base + cru_trim(d32, stack_pointer);
   endsequence

   property p_push_step;
      @(posedge clock) disable iff (sys_rst)
      s_push_issue |=> s_write_at_top
         and cru_trim(d32, $past(stack_pointer) - stack_pointer) ==
             (mem_wide ? `CRU_STEP_DWORD : `CRU_STEP_WORD);
   endproperty
   a_push_step: assert property (p_push_step) else $error("push step or address wrong"); // RL18

   property p_pop_step;
      @(posedge clock) disable iff (sys_rst)
      (ce && state == CRU_ST_POP && mem_req && mem_ack && !is_frame)
         |=> cru_trim(d32, stack_pointer - $past(stack_pointer)) == $past(cur_step);
   endproperty
   a_pop_step: assert property (p_pop_step) else $error("pop step wrong"); // RL1

   property p_width_follows_flag;
      @(posedge clock) disable iff (sys_rst)
      (mem_req && !(op inside {CRU_OP_SAVE_FLW, CRU_OP_SAVE_FLD, CRU_OP_RESTORE_FLW,
                               CRU_OP_RESTORE_FLD})) |-> mem_wide == d32;
   endproperty
   a_width_follows_flag: assert property (p_width_follows_flag) else $error("width wrong"); // RL2

   property p_pop_addr;
      @(posedge clock) disable iff (sys_rst)
      (mem_req && !mem_we && !is_frame) |-> mem_addr == stack_base + cru_trim(d32, stack_pointer);
   endproperty
   a_pop_addr: assert property (p_pop_addr) else $error("pop address wrong"); // RL19

   property p_frame_addr;
      @(posedge clock) disable iff (sys_rst)
      (mem_req && is_frame)
         |-> mem_addr == stack_base + cru_trim(d32, frame_base_pointer + frame_disp);
   endproperty
   a_frame_addr: assert property (p_frame_addr) else $error("frame address wrong"); // RL4

   property p_near_call_target;
      @(posedge clock) disable iff (sys_rst)
      (ce && state == CRU_ST_DONE && op == CRU_OP_NEAR_CALL)
         |=> instruction_pointer == $past(target_off) && fetch_start;
   endproperty
   a_near_call_target: assert property (p_near_call_target) else $error("no jump"); // RL5

   property p_far_call_order;
      @(posedge clock) disable iff (sys_rst)
      (mem_req && mem_we && op inside {CRU_OP_FAR_CALL, CRU_OP_GATE_CALL})
         |-> (idx == 3'h0) ? mem_wdata == {16'h0, code_selector}
                           : mem_wdata == instruction_pointer;
   endproperty
   a_far_call_order: assert property (p_far_call_order) else $error("far push order"); // RL7

   property p_save_all_sp;
      @(posedge clock) disable iff (sys_rst)
      (mem_req && mem_we && op == CRU_OP_SAVE_ALL && idx == `CRU_IDX_SP)
         |-> mem_wdata == entry_sp;
   endproperty
   a_save_all_sp: assert property (p_save_all_sp) else $error("saved pointer wrong"); // RL10

   property p_release;
      @(posedge clock) disable iff (sys_rst)
      (ce && state == CRU_ST_ADJ) |=> state == CRU_ST_DONE
         && cru_trim(d32, stack_pointer - $past(stack_pointer)) == {16'h0, $past(release_bytes)};
   endproperty
   a_release: assert property (p_release) else $error("release count wrong"); // RL6

   property p_fault;
      @(posedge clock) disable iff (sys_rst)
      (accept && ((cmd_op == CRU_OP_FAR_CALL && bad_far)
                  || (cmd_op == CRU_OP_GATE_CALL && bad_gate)))
         |=> state == CRU_ST_FAULT ##1 (!ce || protection_fault);
   endproperty
   a_fault: assert property (p_fault) else $error("missing protection fault"); // RL15

   property p_flags_word;
      @(posedge clock) disable iff (sys_rst)
      (ce && state == CRU_ST_POP && mem_req && mem_ack && op == CRU_OP_RESTORE_FLW)
         |=> flags_register[31:16] == $past(flags_register[31:16])
             && flags_register[15:0] == $past(mem_rdata[15:0]);
   endproperty
   a_flags_word: assert property (p_flags_word) else $error("flags word restore"); // RL13

   property p_stack_switch;
      @(posedge clock) disable iff (sys_rst)
      (accept && cmd_op == CRU_OP_GATE_CALL && !bad_gate && inward)
         |=> saved_stack_pointer == $past(stack_pointer)
             && stack_pointer == $past(tss_stack_pointer);
   endproperty
   a_stack_switch: assert property (p_stack_switch) else $error("stack switch wrong"); // RL17
endmodule

// *** cru_regs.svh ***
`ifndef CRU_REGS_SVH
`define CRU_REGS_SVH
// Function
// (RL1) Step two bytes at 16-bit, four at 32-bit
// (RL2) Step size follows code segment size flag
// (RL3) Software keeps stack pointer aligned to width
// (RL4) Frame pointer references use current stack segment
// (RL5) Near call pushes pointer, loads target offset
// (RL6) Near return pops pointer, adds release count
// (RL7) Far call pushes selector then pointer, loads both
// (RL8) Far return pops pointer then selector, releases
// (RL9) Calls never save registers or flags automatically
// (RL10) Save-all pushes eight registers, original stack pointer
// (RL11) Restore-all reloads all except the source index; code skips the stack pointer slot too
// (RL12) Flags save pushes low word or whole
// (RL13) Flags restore pops low word or whole
// (RL14) Four privilege levels, higher number less privilege
// (RL15) Ungated or unauthorised inward access raises fault
// (RL16) Inward call resolves selector through call gate
// (RL17) Per-level stacks, outer pair saved, inner from table
// (RL18) Push decrements then writes; pop reads then increments
// (RL19) Stack address is segment base plus pointer

`define CRU_STEP_WORD  32'h0000_0002
`define CRU_STEP_DWORD 32'h0000_0004
`define CRU_HALF_MASK  32'h0000_ffff
`define CRU_LIST_LAST  3'h7
`define CRU_IDX_SP     3'h4
`define CRU_IDX_FBP    3'h5
`define CRU_IDX_SI     3'h6
`define CRU_DEST_IP    4'h8
`define CRU_DEST_CS    4'h9
`define CRU_DEST_FLO   4'ha
`define CRU_DEST_FLAGS 4'hb
`define CRU_DEST_LOAD  4'hc
`define CRU_DEST_NONE  4'hf
`define CRU_RST_WORD   32'h0000_0000
`define CRU_RST_SEL    16'h0000
`define CRU_RST_FLAGS  32'h0000_0000
`define CRU_PL_MOST    2'h0
`endif

// *** cru_pkg.sv ***
package cru_pkg;
   typedef enum logic [2:0] {
      CRU_ST_IDLE  = 3'h0,
      CRU_ST_PUSH  = 3'h1,
      CRU_ST_POP   = 3'h3,
      CRU_ST_ADJ   = 3'h2,
      CRU_ST_DONE  = 3'h6,
      CRU_ST_FAULT = 3'h4
   } cru_state_type;

   typedef enum logic [3:0] {
      CRU_OP_PUSH        = 4'h0,
      CRU_OP_POP         = 4'h1,
      CRU_OP_NEAR_CALL   = 4'h2,
      CRU_OP_NEAR_RET    = 4'h3,
      CRU_OP_FAR_CALL    = 4'h4,
      CRU_OP_FAR_RET     = 4'h5,
      CRU_OP_GATE_CALL   = 4'h6,
      CRU_OP_SAVE_ALL    = 4'h7,
      CRU_OP_RESTORE_ALL = 4'h8,
      CRU_OP_SAVE_FLW    = 4'h9,
      CRU_OP_SAVE_FLD    = 4'ha,
      CRU_OP_RESTORE_FLW = 4'hb,
      CRU_OP_RESTORE_FLD = 4'hc,
      CRU_OP_FRAME_READ  = 4'hd
   } cru_op_type;
endpackage

// *** cru_stack_mem.sv ***
`timescale 1ns/1ps
module cru_stack_mem (
   input  wire logic        clock,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic        mem_wide,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [1:0]  slow,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [31:0] mem [int];
   logic [1:0]  waited = 2'h0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 32'h0000_0000;
   // Outside an answer the read data toggles, so a sample one cycle late never sees the stale item.
   always @(posedge clock)
   begin
      if (mem_req && !mem_ack && waited >= slow)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
         if (mem_we)
            mem[mem_addr] = mem_wide ? mem_wdata : {16'h0000, mem_wdata[15:0]};
         waited <= 2'h0;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         waited <= (mem_req && !mem_ack) ? waited + 2'h1 : 2'h0;
      end
   end
endmodule

// *** cru_stack_unit_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module cru_stack_unit_test;
   import cru_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0, code_default_size = 1'b1;
   logic gate_valid = 1'b0, stack_load = 1'b0, gpr_wr = 1'b0, flags_wr = 1'b0, ip_load = 1'b0;
   logic mem_req, mem_we, mem_wide, mem_ack, cmd_ready, op_done, protection_fault;
   cru_op_type  cmd_op = CRU_OP_PUSH;
   logic [1:0]  cmd_target_dpl = 2'h0, gate_dpl = 2'h0, gate_code_dpl = 2'h0, slow = 2'h0;
   logic [2:0]  gpr_wr_idx = 3'h0;
   logic [15:0] cmd_target_sel = 16'h0000, cmd_release = 16'h0000, gate_code_sel = 16'h0000;
   logic [15:0] tss_stack_selector = 16'h0000, stack_load_sel = 16'h0000, code_selector;
   logic [31:0] cmd_value = 32'h0000_0000, cmd_target_off = 32'h0000_0000;
   logic [31:0] cmd_disp = 32'h0000_0000;
   logic [31:0] gate_entry_off = 32'h0000_0000, tss_stack_base = 32'h0000_0000;
   logic [31:0] tss_stack_pointer = 32'h0000_0000, stack_load_base = 32'h0000_1000;
   logic [31:0] stack_load_sp = 32'h0000_0100, gpr_wr_data = 32'h0000_0000;
   logic [31:0] flags_wr_data = 32'h0000_0000, ip_load_value = 32'h0000_4000;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, instruction_pointer, stack_pointer, load_data;
   logic [31:0] lfsr = 32'h0000_a4bb, m_sp, m_ip, v;
   logic [15:0] m_cs = 16'h0000;
   logic [31:0] q[$];
   int n_mismatch = 0, checks_done = 0;
   initial forever #2.5 clock = ~clock;
   cru_stack_unit u_dut (.clock, .sys_rst, .ce, .cmd_valid, .cmd_ready, .cmd_op, .cmd_value,
      .cmd_target_sel, .cmd_target_off, .cmd_target_dpl, .cmd_release, .cmd_disp,
      .code_default_size, .gate_valid, .gate_dpl, .gate_code_sel, .gate_entry_off,
      .gate_code_dpl, .tss_stack_selector, .tss_stack_base, .tss_stack_pointer, .stack_load,
      .stack_load_sel, .stack_load_base, .stack_load_sp, .gpr_wr, .gpr_wr_idx, .gpr_wr_data,
      .flags_wr, .flags_wr_data, .ip_load, .ip_load_value, .mem_req, .mem_we, .mem_wide,
      .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .instruction_pointer, .code_selector,
      .stack_pointer, .frame_base_pointer(), .flags_register(), .stack_selector(),
      .stack_base(), .privilege_level(), .saved_stack_selector(), .saved_stack_pointer(),
      .load_data, .fetch_start(), .op_done, .protection_fault);
   cru_stack_mem u_mem (.clock, .mem_req, .mem_we, .mem_wide, .mem_addr, .mem_wdata, .slow,
      .mem_ack, .mem_rdata);
   function automatic logic [31:0] next_rand();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task complete_run();
      if (n_mismatch == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // The memory answers after a random delay of zero to three cycles for every command that reaches it.
   task run(input cru_op_type op, input logic [31:0] x, input logic [15:0] rel);
      int k;
      k = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_value <= x;
      cmd_target_off <= x;
      cmd_target_sel <= {x[15:2], 2'h0};
      cmd_release <= rel;
      slow <= next_rand() & 2'h3;
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1;
      while (k < 200 && op_done !== 1'b1 && protection_fault !== 1'b1)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      if (k == 200)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask
   initial
   begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      stack_load <= 1'b1;
      ip_load <= 1'b1;
      @(posedge clock);
      stack_load <= 1'b0;
      ip_load <= 1'b0;
      m_sp = 32'h0000_0100;
      m_ip = 32'h0000_4000;
      for (int k = 0; k < 4; k++)
      begin
         code_default_size <= k[0];
         v = next_rand();
         run(CRU_OP_PUSH, v, 16'h0000);
         m_sp = m_sp - (k[0] ? 32'h4 : 32'h2);
         `CHK("push sp", m_sp, stack_pointer)
         `CHK("push addr", k[0] ? v : (v & 32'h0000_ffff), u_mem.mem[32'h1000 + m_sp])
         run(CRU_OP_POP, 32'h0000_0000, 16'h0000);
         m_sp = m_sp + (k[0] ? 32'h4 : 32'h2);
         `CHK("pop data", k[0] ? v : (v & 32'h0000_ffff), load_data)
         `CHK("pop sp", m_sp, stack_pointer)
      end
      code_default_size <= 1'b1;
      v = next_rand() & 32'hffff_fffc;
      run(CRU_OP_NEAR_CALL, v, 16'h0000);
      q.push_front(m_ip);
      m_ip = v;
      m_sp = m_sp - 32'h4;
      `CHK("near call ip", m_ip, instruction_pointer)
      `CHK("near call sp", m_sp, stack_pointer)
      run(CRU_OP_NEAR_RET, 32'h0000_0000, 16'h0008);
      m_ip = q.pop_front();
      m_sp = m_sp + 32'hc;
      `CHK("near ret ip", m_ip, instruction_pointer)
      `CHK("near ret sp", m_sp, stack_pointer)
      v = next_rand() & 32'hffff_fffc;
      run(CRU_OP_FAR_CALL, v, 16'h0000);
      q.push_front({16'h0000, m_cs});
      q.push_front(m_ip);
      m_cs = {v[15:2], 2'h0};
      m_ip = v;
      m_sp = m_sp - 32'h8;
      `CHK("far call cs", m_cs, code_selector)
      `CHK("far call ip", m_ip, instruction_pointer)
      run(CRU_OP_FAR_RET, 32'h0000_0000, 16'h0004);
      m_ip = q.pop_front();
      m_cs = q.pop_front() & 32'h0000_ffff;
      m_sp = m_sp + 32'hc;
      `CHK("far ret ip", m_ip, instruction_pointer)
      `CHK("far ret cs", m_cs, code_selector)
      `CHK("far ret sp", m_sp, stack_pointer)
      run(CRU_OP_SAVE_ALL, 32'h0000_0000, 16'h0000);
      m_sp = m_sp - 32'h20;
      `CHK("save all sp", m_sp, stack_pointer)
      `CHK("saved sp", m_sp + 32'h20, u_mem.mem[32'h1000 + m_sp + 32'hc])
      run(CRU_OP_RESTORE_ALL, 32'h0000_0000, 16'h0000);
      m_sp = m_sp + 32'h20;
      `CHK("restore all sp", m_sp, stack_pointer)
      run(CRU_OP_GATE_CALL, next_rand(), 16'h0000);
      `CHK("gate fault", 1'b1, protection_fault)
      `CHK("gate sp", m_sp, stack_pointer)
      complete_run();
   end
endmodule
